// >>> rtl/boot_cfg_params.svh
// Constants for the boot configuration sampler.
`ifndef BOOT_CFG_PARAMS_SVH
`define BOOT_CFG_PARAMS_SVH
// ============================================================
// Boot mode codes, switch ON reads as a one.
`define BOOT_DEF_SDR 2'h0
`define BOOT_DEF_DDR 2'h1
`define BOOT_OVERRIDE 2'h2
`define BOOT_RESERVED 2'h3
// ============================================================
// Bit positions inside the sampled lines 21 down to 16.
`define CFG_BIT_MASTER 0
`define CFG_BIT_BUS 1
`define CFG_BIT_OSC 2
`define CFG_BIT_DRIVE 3
`define CFG_BIT_WIDTH 4
`define CFG_BIT_CSMAP 5
// ============================================================
// Port width codes.
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h2
`endif

// >>> rtl/boot_cfg_pkg.sv
// Types for the boot configuration sampler.
package boot_cfg_pkg;
  // Decoded configuration handed to the rest of the chip.
  typedef struct packed {
    logic master_mode;
    logic sdr_unified;
    logic osc_bypass;
    logic drive_high;
    logic [1:0] port_width;
    logic cs_addr_map;
    logic cfg_reserved;
  } boot_cfg_t;
endpackage

// >>> rtl/reset_boot_config_sampler.sv
// Boot configuration sampler, captured while the reset output is asserted.
`timescale 1ns/100ps
`include "boot_cfg_params.svh"
// ============================================================
// Sampler
// While reset-out is asserted the sampler keeps loading the configuration
// decoded from the board levels. The first edge that sees reset-out released
// sets the lock, and from then on the configuration stands until rst_n.
// Limitation: a board that moves its switches inside the window gets whatever
// was decoded on the last edge before release; nothing here debounces them.
module reset_boot_config_sampler
(
  // Clock and asynchronous active-low reset.
  input wire logic mclk, // Core clock, rising edge.
  input wire logic rst_n, // Clears the sampler and unlocks it.
  // Board-driven levels, asynchronous to mclk, synchronised below.
  input wire logic [1:0] boot_mode_select, // Boot mode pair, switch ON reads as one.
  input wire logic [5:0] ext_addr_cfg_lines, // Lines 21 down to 16, bit 0 is line 16.
  // Reset output level, low while asserted.
  input wire logic reset_out_n, // Sampling window while low.
  // Results, both straight from flip-flops.
  output boot_cfg_pkg::boot_cfg_t boot_cfg, // Decoded boot configuration.
  output logic cfg_locked // High once the configuration is frozen.
);
  import boot_cfg_pkg::*;

  // ============================================================
  // State
  // Synchroniser stages, then the held configuration.
  // Every board level passes two flip-flops before the decoder reads it, so a
  // switch that moves near a clock edge cannot reach the decoder half-settled.
  typedef struct packed {
    logic [1:0] mode_s1; // Boot mode pair, first stage.
    logic [1:0] mode_s2; // Boot mode pair, second stage, read by the decoder.
    logic [5:0] addr_s1; // Configuration lines, first stage.
    logic [5:0] addr_s2; // Configuration lines, second stage, read by the decoder.
    logic rst_s1; // Reset-out level, first stage.
    logic rst_s2; // Reset-out level, second stage; low means still sampling.
    logic locked; // Set once reset-out has been seen released.
    boot_cfg_t cfg; // The configuration handed to the rest of the chip.
  } sampler_state_t;

  // Registered state and its next value.
  sampler_state_t st; // Present state.
  sampler_state_t next_st; // Value loaded at the next clock edge.
  // Combinational decode of the synchronised levels.
  boot_cfg_t decoded; // Configuration the present levels would give.

  // ============================================================
  // Decode the synchronised pins into a configuration.
  // Outside override mode only the bus arrangement and the reserved flag follow the mode pair;
  // the other fields take the fixed defaults set at the top of the process.
  always_comb
  begin
    // Defaults: master mode, 16-bit port, low drive, crystal, plain mapping.
    decoded = '0;
    decoded.master_mode = 1'h1;
    decoded.port_width = `WIDTH_16;
    // Mode comes from the synchronised select pair.
    case (st.mode_s2)
      `BOOT_DEF_SDR:
      begin
        // Defaults with a unified SDR bus.
        decoded.sdr_unified = 1'h1;
      end
      `BOOT_DEF_DDR:
      begin
        // Defaults with a split DDR bus.
        decoded.sdr_unified = 1'h0;
      end
      `BOOT_OVERRIDE:
      begin
        // Each field follows its own line; switch ON reads as a one.
        decoded.master_mode = st.addr_s2[`CFG_BIT_MASTER];
        decoded.sdr_unified = st.addr_s2[`CFG_BIT_BUS];
        decoded.osc_bypass = st.addr_s2[`CFG_BIT_OSC];
        decoded.drive_high = st.addr_s2[`CFG_BIT_DRIVE];
        decoded.cs_addr_map = st.addr_s2[`CFG_BIT_CSMAP];
        // Width depends on both the width line and the bus choice.
        if (st.addr_s2[`CFG_BIT_WIDTH])
        begin
          // ON: 32-bit on a unified bus, 8-bit on a split bus.
          decoded.port_width = st.addr_s2[`CFG_BIT_BUS] ? `WIDTH_32 : `WIDTH_8;
        end
        else
        begin
          // OFF: 16-bit on either bus arrangement.
          decoded.port_width = `WIDTH_16;
        end
      end
      default:
      begin
        // Reserved code: board must not apply it; flag it and use SDR defaults.
        decoded.sdr_unified = 1'h1;
        decoded.cfg_reserved = 1'h1;
      end
    endcase
  end

  // ============================================================
  // Next-state: follow the pins while reset-out is low, then freeze.
  // The synchronisers run on every edge; only the configuration and the lock
  // depend on where the sampler stands.
  always_comb
  begin
    next_st = st;
    // Two-stage synchronisers for every board level.
    next_st.mode_s1 = boot_mode_select;
    next_st.mode_s2 = st.mode_s1;
    next_st.addr_s1 = ext_addr_cfg_lines;
    next_st.addr_s2 = st.addr_s1;
    next_st.rst_s1 = reset_out_n;
    next_st.rst_s2 = st.rst_s1;
    if (!st.locked)
    begin
      // Sample while reset-out is asserted.
      if (!st.rst_s2)
      begin
        // Keep loading so the last value before release is the one held.
        next_st.cfg = decoded;
      end
      else
      begin
        // Reset-out released: hold until the next reset.
        // The configuration is not loaded on this edge, so the value held is
        // the one decoded from levels seen while reset-out was still low.
        next_st.locked = 1'h1;
      end
    end
  end

  // ============================================================
  // Registers; reset clears every field and leaves the sampler unlocked.
  // The reset-out stage clears to low, so the window is open from the first
  // edge after rst_n rises; the board levels reach the decoder two edges after that.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ============================================================
  // Outputs
  // Both outputs come straight from flip-flops.
  assign boot_cfg = st.cfg; // Held configuration.
  assign cfg_locked = st.locked; // Lock flag.

  // ============================================================
  // Checks
  // Each sampling check looks one edge after an edge that loads the configuration,
  // so the load and the comparison stay in the mclk domain.
  // Reset is asynchronous, so every check but the reset one is disabled by it.
  chk_hold_after_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_locked |=> ($stable(boot_cfg) && cfg_locked))
    else $error("configuration changed after lock");
  chk_sample_in_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2) |=> (boot_cfg == $past(decoded)))
    else $error("configuration not sampled during reset-out");
  chk_bus_select: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_OVERRIDE)
    |=> (boot_cfg.sdr_unified == $past(st.addr_s2[`CFG_BIT_BUS])))
    else $error("bus arrangement mismatch");
  chk_drive_select: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_OVERRIDE)
    |=> (boot_cfg.drive_high == $past(st.addr_s2[`CFG_BIT_DRIVE])))
    else $error("drive strength mismatch");
  chk_width_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_OVERRIDE
     && !st.addr_s2[`CFG_BIT_WIDTH]) |=> (boot_cfg.port_width == `WIDTH_16))
    else $error("port width not 16 bit");
  chk_width_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_OVERRIDE
     && st.addr_s2[`CFG_BIT_WIDTH])
    |=> (boot_cfg.port_width == ($past(st.addr_s2[`CFG_BIT_BUS]) ? `WIDTH_32 : `WIDTH_8)))
    else $error("port width wrong for bus");
  chk_default_ddr: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_DEF_DDR)
    |=> (!boot_cfg.sdr_unified && boot_cfg.port_width == `WIDTH_16))
    else $error("ddr default wrong");
  chk_default_sdr: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_DEF_SDR)
    |=> (boot_cfg.sdr_unified && !boot_cfg.drive_high))
    else $error("sdr default wrong");
  chk_lock_release: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && st.rst_s2) |=> cfg_locked)
    else $error("lock missing after release");
  // Override fields that only the sampling rule covers.
  chk_master_select: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_OVERRIDE)
    |=> (boot_cfg.master_mode == $past(st.addr_s2[`CFG_BIT_MASTER])))
    else $error("master mode mismatch");
  chk_osc_select: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_OVERRIDE)
    |=> (boot_cfg.osc_bypass == $past(st.addr_s2[`CFG_BIT_OSC])))
    else $error("oscillator mode mismatch");
  chk_csmap_select: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_OVERRIDE)
    |=> (boot_cfg.cs_addr_map == $past(st.addr_s2[`CFG_BIT_CSMAP])))
    else $error("chip-select mapping mismatch");
  chk_reserved_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 == `BOOT_RESERVED)
    |=> (boot_cfg.cfg_reserved && boot_cfg.sdr_unified))
    else $error("reserved mode not flagged");
  chk_legal_no_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_locked && !st.rst_s2 && st.mode_s2 != `BOOT_RESERVED)
    |=> !boot_cfg.cfg_reserved)
    else $error("reserved flag on a legal mode");
  chk_clear_in_reset: assert property (@(posedge mclk)
    (!rst_n ##1 !rst_n) |-> (boot_cfg == '0 && !cfg_locked))
    else $error("outputs not cleared in reset");
  // Covers for the main boot scenarios.
  cov_override: cover property (@(posedge mclk) disable iff (!rst_n)
    st.mode_s2 == `BOOT_OVERRIDE ##1 cfg_locked);
  cov_ddr: cover property (@(posedge mclk) disable iff (!rst_n)
    st.mode_s2 == `BOOT_DEF_DDR ##1 cfg_locked);
  cov_reserved: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg_locked && boot_cfg.cfg_reserved);
  cov_sdr: cover property (@(posedge mclk) disable iff (!rst_n)
    st.mode_s2 == `BOOT_DEF_SDR ##1 cfg_locked);
  cov_wide_port: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg_locked && boot_cfg.port_width == `WIDTH_32);
endmodule

// >>> tb/boot_switch_board.sv
// Board switch model that drives the boot configuration pins.
`timescale 1ns/100ps
module boot_switch_board
(
  input wire logic [1:0] mode_sw,
  input wire logic [5:0] cfg_sw,
  output logic [1:0] boot_mode_select,
  output logic [5:0] ext_addr_cfg_lines
);
  // ========
  // Switch ON reads as a one on each pin.
  assign boot_mode_select = mode_sw;
  // Levels follow the switches, which the bench sets while rst_n is low and moves again after lock.
  assign ext_addr_cfg_lines = cfg_sw;
endmodule

// >>> tb/reset_boot_config_sampler_tb.sv
// Self-checking bench for the boot configuration sampler.
`timescale 1ns/100ps
module reset_boot_config_sampler_tb;
  import boot_cfg_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic reset_out_n = 1'h0;
  logic [1:0] mode_sw = 2'h0;
  logic [5:0] cfg_sw = 6'h00;
  logic [1:0] boot_mode_select;
  logic [5:0] ext_addr_cfg_lines;
  boot_cfg_t boot_cfg;
  logic cfg_locked;
  int miscompares = 0;
  int cmp_count = 0;
  // ========
  // The clock is 125 MHz.
  initial forever #4 mclk = ~mclk;
  boot_switch_board board (.mode_sw(mode_sw), .cfg_sw(cfg_sw),
    .boot_mode_select(boot_mode_select), .ext_addr_cfg_lines(ext_addr_cfg_lines));
  reset_boot_config_sampler dut (.mclk(mclk), .rst_n(rst_n),
    .boot_mode_select(boot_mode_select), .ext_addr_cfg_lines(ext_addr_cfg_lines),
    .reset_out_n(reset_out_n), .boot_cfg(boot_cfg), .cfg_locked(cfg_locked));
  // Expected decode, worked out from the switch meanings.
  function automatic logic [7:0] exp_cfg(logic [1:0] m, logic [5:0] a);
    if (m != 2'h2)
      return {1'h1, m != 2'h1, 4'h1, 1'h0, m == 2'h3};
    return {a[0], a[1], a[2], a[3], a[4] ? {a[1], 1'h0} : 2'h1, a[5], 1'h0};
  endfunction
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Mismatches %0d of %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One boot: sample during reset-out, lock, then disturb the pins.
  task automatic boot(logic [1:0] m, logic [5:0] a);
    @(negedge mclk);
    rst_n = 1'h0;
    reset_out_n = 1'h0;
    mode_sw = m;
    cfg_sw = a;
    repeat (3) @(negedge mclk);
    rst_n = 1'h1;
    repeat (4) @(negedge mclk);
    check("sampled", exp_cfg(m, a), boot_cfg);
    check("early lock", 8'h00, {7'h0, cfg_locked});
    reset_out_n = 1'h1;
    for (int i = 0; i < 8 && cfg_locked !== 1'h1; i++)
      @(negedge mclk);
    check("locked", 8'h01, {7'h0, cfg_locked});
    if (cfg_locked !== 1'h1)
      finish_test();
    // Invert every configuration line; the mode goes to a legal code, never the reserved one.
    cfg_sw = ~a;
    mode_sw = (m == 2'h2) ? 2'h0 : 2'h2;
    repeat (5) @(negedge mclk);
    check("held", exp_cfg(m, a), boot_cfg);
  endtask
  // Default modes, the reserved code and its reserved flag.
  task automatic test_modes();
    boot(2'h0, 6'h3a);
    boot(2'h1, 6'h3f);
    boot(2'h3, 6'h15);
  endtask
  // Override patterns hit every width and each line both ON and OFF.
  task automatic test_override();
    boot(2'h2, 6'h3f);
    boot(2'h2, 6'h10);
    boot(2'h2, 6'h00);
    boot(2'h2, 6'h2a);
    boot(2'h2, 6'h15);
  endtask
  initial
  begin
    test_modes();
    test_override();
    finish_test();
  end
endmodule
